//--- cstc_pkg.sv
/*
 * Shared constants and carrier types for the CPU status and Timer0
 * control register block.
 * Assumes an 8-bit core data bus and one instruction clock domain.
 */
package cstc_pkg;

    // Bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Register addresses on the core data bus
    localparam logic [ADDR_W-1:0] TIMER0_CONTROL_ADDR = 8'h05;
    localparam logic [ADDR_W-1:0] CPU_STATUS_ADDR = 8'h06;
    localparam logic [ADDR_W-1:0] EVENT_STATUS_ADDR = 8'h07;
    localparam logic [ADDR_W-1:0] EVENT_MASK_ADDR = 8'h08;

    // cpu_status fields
    localparam int CPU_STACK_AVAILABLE_FLAG_BIT = 5;
    localparam int CPU_GLOBAL_INTERRUPT_DISABLE_BIT = 4;
    localparam int CPU_TO_BIT = 3;
    localparam int CPU_PD_BIT = 2;
    localparam int CPU_POR_BIT = 1;
    localparam int CPU_BOR_BIT = 0;
    localparam logic [DATA_W-1:0] CPU_STATUS_RESET = 8'h3d;
    // Only these bits take a software write
    localparam logic [DATA_W-1:0] CPU_STATUS_WR_MASK = 8'h13;

    // timer0_control fields
    localparam int T0_INT_EDGE_BIT = 7;
    localparam int T0_EXT_EDGE_BIT = 6;
    localparam int T0_CLK_SRC_BIT = 5;
    localparam int T0_PS_LSB = 1;
    localparam int T0_PS_W = 4;
    localparam logic [DATA_W-1:0] TIMER0_CONTROL_RESET = 8'h00;
    localparam logic [DATA_W-1:0] TIMER0_CONTROL_WR_MASK = 8'hfe;

    // Prescaler: codes with the top bit set select the largest ratio
    localparam int PS_CNT_W = 8;
    localparam logic [3:0] PS_MAX_SHIFT = 4'h8;

    // Stack pointer
    localparam int SP_W = 4;
    localparam logic [SP_W-1:0] SP_TOP = 4'hf;
    localparam logic [SP_W-1:0] SP_RESET = 4'h0;

    // Event status / mask layout
    localparam int EV_W = 5;
    localparam int EV_EXT_INT = 0;
    localparam int EV_TIMER_PIN = 1;
    localparam int EV_TIMER_INC = 2;
    localparam int EV_STACK_WRAP = 3;
    localparam int EV_WDT_TIMEOUT = 4;
    localparam logic [EV_W-1:0] EV_RESET = 5'h00;

    // Register bus request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } cstc_bus_req_t;

    // One-cycle pulses from the core, watchdog and reset logic
    typedef struct packed {
        logic clear_watchdog_instruction;
        logic sleep;
        logic watchdog_timeout;
        logic device_reset;
        logic power_on_reset;
        logic brown_out_reset;
        logic push;
        logic pop;
    } cstc_core_evt_t;

endpackage

//--- cstc_prescaler.sv
/*
 * Timer0 prescaler: passes one increment per 2**code selected events, 256 for codes with the top bit set.
 * Assumes event_i is a one-cycle pulse in the clk_i domain.
 */
`timescale 1ns/100ps
module cstc_prescaler
    import cstc_pkg::*;
#(
    parameter int CNT_W = PS_CNT_W
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Control
    input wire logic clear_i,
    input wire logic event_i,
    input wire logic [T0_PS_W-1:0] select_i,
    // Result
    output logic tick_o
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic tick;
    } cstc_ps_state_t;

    cstc_ps_state_t state;
    cstc_ps_state_t next_state;
    logic [3:0] shift;
    logic [CNT_W:0] mask_wide;
    logic [CNT_W-1:0] mask;

    always_comb begin
        next_state = state;
        next_state.tick = 1'b0;
        shift = select_i[T0_PS_W-1] ? PS_MAX_SHIFT : {1'b0, select_i[2:0]};
        mask_wide = ((CNT_W+1)'(1) << shift) - (CNT_W+1)'(1);
        mask = mask_wide[CNT_W-1:0];
        if (clear_i) begin
            next_state.cnt = '0;
        end else if (event_i) begin
            if ((state.cnt & mask) == mask) begin
                next_state.cnt = '0;
                next_state.tick = 1'b1;
            end else begin
                next_state.cnt = state.cnt + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign tick_o = state.tick;

endmodule // cstc_prescaler

//--- cstc_stack_mon.sv
/*
 * Stack pointer shadow and stack-available flag.
 * Assumes push_i and pop_i are one-cycle pulses, never together.
 */
`timescale 1ns/100ps
module cstc_stack_mon
    import cstc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic stack_reset_i,
    // Stack actions
    input wire logic push_i,
    input wire logic pop_i,
    // Status
    output logic stack_available_o,
    output logic stack_wrap_o,
    output logic [SP_W-1:0] stack_pointer_o
);

    typedef struct packed {
        logic [SP_W-1:0] sp;
        logic locked;
        logic avail;
        logic wrap;
    } cstc_stk_state_t;

    cstc_stk_state_t state;
    cstc_stk_state_t next_state;

    always_comb begin
        next_state = state;
        next_state.wrap = 1'b0;
        if (stack_reset_i) begin
            next_state.sp = SP_RESET;
            next_state.locked = 1'b0;
        end else if (push_i && !pop_i) begin
            next_state.sp = state.sp + SP_W'(1);
            // A push from the top wraps; the flag stays low until reset
            if (state.sp == SP_TOP) begin
                next_state.locked = 1'b1;
                next_state.wrap = 1'b1;
            end
        end else if (pop_i && !push_i) begin
            next_state.sp = state.sp - SP_W'(1);
        end
        next_state.avail = !next_state.locked &&
            (next_state.sp != SP_TOP);
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state <= '{sp: SP_RESET, locked: 1'b0, avail: 1'b1,
                wrap: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    assign stack_available_o = state.avail;
    assign stack_wrap_o = state.wrap;
    assign stack_pointer_o = state.sp;

endmodule // cstc_stack_mon

//--- cstc_regs.sv
/*
 * CPU status and Timer0 control registers with pin edge selection,
 * Timer0 clock selection, prescaler and a small event interrupt unit.
 * Assumes a single-cycle register port, pins already synchronous to
 * clk_i, and core event pulses one cycle long.
 */
// Local design decision: the address-and-strobe port.
//
// Function
// - Unused status and control bits read zero
// - Stack flag low at top or wrap
// - Wrap locks stack flag low until reset
// - Global disable blocks every interrupt
// - Only enabled sources may interrupt
// - Timeout flag: set by clear/sleep, cleared by timeout
// - Power-down flag: clear sets, sleep clears
// - Power-on reset clears flag; software sets it
// - Brown-out reset clears flag when detection on
// - Interrupt pin edge chosen by select bit
// - External timer edge chosen by select bit
// - Edge select ignored for counting with internal clock
// - Source bit picks instruction clock or pin
// - Prescale code selects ratio, top bit 1:256
// - Writes never touch hardware-owned flags
// - reset_i and device reset zero pointer, set stack flag
//
`timescale 1ns/100ps
module cstc_regs
    import cstc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Register port
    input wire cstc_bus_req_t bus_i,
    output logic [DATA_W-1:0] rdata_o,
    // Core, watchdog and reset events
    input wire cstc_core_evt_t core_i,
    input wire logic brown_out_detect_enable_i,
    // Pins and clock enables
    input wire logic ext_interrupt_pin_i,
    input wire logic timer_clock_pin_i,
    input wire logic instruction_cycle_clock_i,
    // Results
    output logic irq_o,
    output logic global_interrupt_disable_o,
    output logic ext_interrupt_flag_o,
    output logic timer_clock_pin_flag_o,
    output logic timer_increment_o,
    output logic stack_available_o,
    output logic [SP_W-1:0] stack_pointer_o
);

    typedef struct packed {
        logic [DATA_W-1:0] cpu_status;
        logic [DATA_W-1:0] timer0_control;
        logic [EV_W-1:0] ev_status;
        logic [EV_W-1:0] ev_mask;
        logic [DATA_W-1:0] rdata;
        logic irq;
        logic ext_pin_d;
        logic tmr_pin_d;
        logic ext_flag;
        logic tmr_flag;
    } cstc_regs_state_t;

    cstc_regs_state_t state;
    cstc_regs_state_t next_state;

    logic stack_available;
    logic stack_wrap;
    logic timer_tick;
    logic stack_reset;
    logic ext_edge;
    logic tmr_edge;
    logic ext_rise;
    logic ext_fall;
    logic tmr_rise;
    logic tmr_fall;
    logic count_event;
    logic ps_clear;
    logic wr_cpu;
    logic wr_t0;
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] ev_clr;
    logic [DATA_W-1:0] cpu_read;

    assign stack_reset = core_i.device_reset;

    cstc_stack_mon u_stack (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .stack_reset_i(stack_reset),
        .push_i(core_i.push),
        .pop_i(core_i.pop),
        .stack_available_o(stack_available),
        .stack_wrap_o(stack_wrap),
        .stack_pointer_o(stack_pointer_o)
    );

    cstc_prescaler #(
        .CNT_W(PS_CNT_W)
    ) u_prescaler (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .clear_i(ps_clear),
        .event_i(count_event),
        .select_i(state.timer0_control[T0_PS_LSB +: T0_PS_W]),
        .tick_o(timer_tick)
    );

    // Pin edges, sampled against last cycle's level
    always_comb begin
        ext_rise = ext_interrupt_pin_i && !state.ext_pin_d;
        ext_fall = !ext_interrupt_pin_i && state.ext_pin_d;
        tmr_rise = timer_clock_pin_i && !state.tmr_pin_d;
        tmr_fall = !timer_clock_pin_i && state.tmr_pin_d;
        ext_edge = state.timer0_control[T0_INT_EDGE_BIT] ?
            ext_rise : ext_fall;
        tmr_edge = state.timer0_control[T0_EXT_EDGE_BIT] ?
            tmr_rise : tmr_fall;
        // Internal source ignores the pin and its edge select
        count_event = state.timer0_control[T0_CLK_SRC_BIT] ?
            instruction_cycle_clock_i : tmr_edge;
    end

    // Register decode
    always_comb begin
        wr_cpu = bus_i.wr && (bus_i.addr == CPU_STATUS_ADDR);
        wr_t0 = bus_i.wr && (bus_i.addr == TIMER0_CONTROL_ADDR);
        // Reprogramming the timer restarts the prescale count
        ps_clear = wr_t0;
        cpu_read = state.cpu_status;
        cpu_read[CPU_STACK_AVAILABLE_FLAG_BIT] = stack_available;
        cpu_read[DATA_W-1:CPU_STACK_AVAILABLE_FLAG_BIT+1] = '0;
    end

    // Interrupt events
    always_comb begin
        ev_set = '0;
        ev_set[EV_EXT_INT] = ext_edge;
        ev_set[EV_TIMER_PIN] = tmr_edge;
        ev_set[EV_TIMER_INC] = timer_tick;
        ev_set[EV_STACK_WRAP] = stack_wrap;
        ev_set[EV_WDT_TIMEOUT] = core_i.watchdog_timeout;
        ev_clr = '0;
        if (bus_i.rd && (bus_i.addr == EVENT_STATUS_ADDR)) begin
            ev_clr = state.ev_status;
        end
    end

    always_comb begin
        next_state = state;
        next_state.ext_pin_d = ext_interrupt_pin_i;
        next_state.tmr_pin_d = timer_clock_pin_i;
        next_state.ext_flag = ext_edge;
        next_state.tmr_flag = tmr_edge;

        // Software writes: only writable bits move
        if (wr_cpu) begin
            next_state.cpu_status = (state.cpu_status &
                ~CPU_STATUS_WR_MASK) |
                (bus_i.wdata & CPU_STATUS_WR_MASK);
        end
        if (wr_t0) begin
            next_state.timer0_control = bus_i.wdata &
                TIMER0_CONTROL_WR_MASK;
        end
        if (bus_i.wr && (bus_i.addr == EVENT_MASK_ADDR)) begin
            next_state.ev_mask = bus_i.wdata[EV_W-1:0];
        end

        // Hardware-owned flags; these win over a same-cycle write
        if (core_i.clear_watchdog_instruction) begin
            next_state.cpu_status[CPU_TO_BIT] = 1'b1;
            next_state.cpu_status[CPU_PD_BIT] = 1'b1;
        end
        if (core_i.sleep) begin
            next_state.cpu_status[CPU_TO_BIT] = 1'b1;
            next_state.cpu_status[CPU_PD_BIT] = 1'b0;
        end
        if (core_i.watchdog_timeout) begin
            next_state.cpu_status[CPU_TO_BIT] = 1'b0;
        end
        if (core_i.power_on_reset) begin
            next_state.cpu_status[CPU_POR_BIT] = 1'b0;
            next_state.cpu_status[CPU_TO_BIT] = 1'b1;
            next_state.cpu_status[CPU_PD_BIT] = 1'b1;
        end
        // With detection off the flag is left to software alone
        if (core_i.brown_out_reset && brown_out_detect_enable_i) begin
            next_state.cpu_status[CPU_BOR_BIT] = 1'b0;
        end
        next_state.cpu_status[DATA_W-1:CPU_STACK_AVAILABLE_FLAG_BIT] = '0;

        // Sticky events: a set in the clearing cycle survives
        next_state.ev_status = (state.ev_status & ~ev_clr) | ev_set;

        // Read data for the cycle after the strobe
        next_state.rdata = '0;
        if (bus_i.rd) begin
            unique case (bus_i.addr)
                CPU_STATUS_ADDR: next_state.rdata = cpu_read;
                TIMER0_CONTROL_ADDR: begin
                    next_state.rdata = state.timer0_control;
                end
                EVENT_STATUS_ADDR: begin
                    next_state.rdata = DATA_W'(state.ev_status);
                end
                EVENT_MASK_ADDR: begin
                    next_state.rdata = DATA_W'(state.ev_mask);
                end
                default: next_state.rdata = '0;
            endcase
        end

        // Masked sources stay silent; global disable blocks all
        next_state.irq =
            !next_state.cpu_status[CPU_GLOBAL_INTERRUPT_DISABLE_BIT] &&
            |(next_state.ev_status & next_state.ev_mask);
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            // Power-on: POR reads 0 until software sets it
            state <= '{cpu_status: CPU_STATUS_RESET & ~CPU_STATUS_WR_MASK
                    | (CPU_STATUS_RESET & CPU_STATUS_WR_MASK),
                timer0_control: TIMER0_CONTROL_RESET,
                ev_status: EV_RESET,
                ev_mask: EV_RESET,
                rdata: '0,
                irq: 1'b0,
                ext_pin_d: 1'b0,
                tmr_pin_d: 1'b0,
                ext_flag: 1'b0,
                tmr_flag: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    assign rdata_o = state.rdata;
    assign irq_o = state.irq;
    assign global_interrupt_disable_o = state.cpu_status[CPU_GLOBAL_INTERRUPT_DISABLE_BIT];
    assign ext_interrupt_flag_o = state.ext_flag;
    assign timer_clock_pin_flag_o = state.tmr_flag;
    assign timer_increment_o = timer_tick;
    assign stack_available_o = stack_available;

endmodule // cstc_regs

//--- cstc_regs_sva.sv
/* Port checker for cstc_regs, bound to every instance.
   Assumes both pins are held low while reset_i is high. */
`timescale 1ns/100ps
module cstc_regs_sva
    import cstc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Watched ports
    input wire cstc_bus_req_t bus_i,
    input wire logic [DATA_W-1:0] rdata_o,
    input wire cstc_core_evt_t core_i,
    input wire logic ext_interrupt_pin_i,
    input wire logic timer_clock_pin_i,
    input wire logic irq_o,
    input wire logic global_interrupt_disable_o,
    input wire logic ext_interrupt_flag_o,
    input wire logic timer_clock_pin_flag_o,
    input wire logic stack_available_o,
    input wire logic [SP_W-1:0] stack_pointer_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    rsvd_cpu_a: assert property (
        $past(bus_i.rd) && $past(bus_i.addr) == CPU_STATUS_ADDR
        |-> rdata_o[7:6] == 2'h0) else $error("status top bits set");
    rsvd_t0_a: assert property (
        $past(bus_i.rd) && $past(bus_i.addr) == TIMER0_CONTROL_ADDR
        |-> !rdata_o[0]) else $error("control bit 0 set");
    stack_read_a: assert property (
        $past(bus_i.rd) && $past(bus_i.addr) == CPU_STATUS_ADDR
        |-> rdata_o[CPU_STACK_AVAILABLE_FLAG_BIT] == $past(stack_available_o))
        else $error("stack flag read wrong");
    stack_top_a: assert property (
        stack_pointer_o == SP_TOP |-> !stack_available_o)
        else $error("stack flag high at top");
    wrap_lock_a: assert property (
        !stack_available_o && stack_pointer_o == SP_RESET
        && !core_i.device_reset |=> !stack_available_o)
        else $error("stack lock released");
    dev_reset_a: assert property (
        core_i.device_reset |=> stack_available_o
        && stack_pointer_o == SP_RESET) else $error("stack not reset");
    irq_block_a: assert property (
        global_interrupt_disable_o && $past(global_interrupt_disable_o)
        |-> !irq_o) else $error("irq while disabled");
    wr_protect_a: assert property (
        bus_i.wr && bus_i.addr == CPU_STATUS_ADDR && core_i == '0
        |=> $stable(stack_available_o)) else $error("write moved flag");
    ext_edge_a: assert property (
        ext_interrupt_flag_o |-> $past(ext_interrupt_pin_i)
        != $past(ext_interrupt_pin_i, 2) || $past(ext_interrupt_pin_i, 2)
        != $past(ext_interrupt_pin_i, 3)) else $error("pin flag no edge");
    pin_edge_a: assert property (
        timer_clock_pin_flag_o |-> $past(timer_clock_pin_i)
        != $past(timer_clock_pin_i, 2) || $past(timer_clock_pin_i, 2)
        != $past(timer_clock_pin_i, 3)) else $error("timer flag no edge");

    wrap_c: cover property (!stack_available_o && stack_pointer_o == 4'h0);
    irq_c: cover property (irq_o);
    pin_c: cover property (timer_clock_pin_flag_o);
endmodule // cstc_regs_sva

bind cstc_regs cstc_regs_sva u_sva (.clk_i(clk_i), .reset_i(reset_i),
    .bus_i(bus_i), .rdata_o(rdata_o), .core_i(core_i),
    .ext_interrupt_pin_i(ext_interrupt_pin_i),
    .timer_clock_pin_i(timer_clock_pin_i), .irq_o(irq_o),
    .global_interrupt_disable_o(global_interrupt_disable_o),
    .ext_interrupt_flag_o(ext_interrupt_flag_o),
    .timer_clock_pin_flag_o(timer_clock_pin_flag_o),
    .stack_available_o(stack_available_o),
    .stack_pointer_o(stack_pointer_o));

//--- cstc_regs_bench.sv
/* Self-checking bench for cstc_regs: register port tasks, pin edges,
   core event pulses. Brown-out detection is enabled except in one
   scenario that checks the flag is left alone without it. */
`timescale 1ns/100ps
module cstc_regs_bench
    import cstc_pkg::*;
;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    cstc_bus_req_t bus = '0;
    cstc_core_evt_t core = '0;
    logic bod = 1'b1, ipin = 1'b0, tpin = 1'b0, icc = 1'b0;
    logic irq, global_interrupt_disable, ext_flag, pin_flag, inc, stk_av;
    logic [7:0] rdata;
    logic [3:0] sp, code;
    int err_count = 0, tests_run = 0, cycles = 0, inc_seen = 0, n, base;
    int ext_seen = 0, pin_seen = 0;

    cstc_regs dut (.clk_i(clk_i), .reset_i(reset_i), .bus_i(bus),
        .rdata_o(rdata), .core_i(core), .brown_out_detect_enable_i(bod),
        .ext_interrupt_pin_i(ipin), .timer_clock_pin_i(tpin),
        .instruction_cycle_clock_i(icc), .irq_o(irq),
        .global_interrupt_disable_o(global_interrupt_disable),
        .ext_interrupt_flag_o(ext_flag), .timer_clock_pin_flag_o(pin_flag),
        .timer_increment_o(inc), .stack_available_o(stk_av),
        .stack_pointer_o(sp));

    always #25 clk_i = ~clk_i;

    task automatic final_report;
        $display("checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Pre-edge increment level is counted, so no race with the flop
    always @(posedge clk_i) begin
        cycles++;
        if (inc === 1'b1) inc_seen++;
        // One-cycle flag pulses are counted so none can slip past a check
        if (ext_flag === 1'b1) ext_seen++;
        if (pin_flag === 1'b1) pin_seen++;
        if (cycles == 20000) begin
            err_count++;
            final_report();
        end
    end

    task automatic chk(input string nm, input logic [7:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
            err_count++;
        end
    endtask

    // Every bus, event and cycle task ends 1 ns after an edge so results have landed
    task automatic wr(input logic [7:0] a, d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        bus <= '0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, exp, input string nm);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        bus <= '0;
        #1;
        chk(nm, exp, rdata);
    endtask

    task automatic evt(input logic [7:0] e);
        core <= cstc_core_evt_t'(e);
        @(posedge clk_i);
        core <= '0;
        #1;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask

    task automatic tick;
        icc <= 1'b1;
        @(posedge clk_i);
        icc <= 1'b0;
        cyc(1);
    endtask

    initial begin
        repeat (12) @(posedge clk_i);
        reset_i <= 1'b0;
        cyc(1);
        rd(CPU_STATUS_ADDR, 8'h3d, "status reset");
        rd(TIMER0_CONTROL_ADDR, 8'h00, "control reset");
        rd(EVENT_STATUS_ADDR, 8'h00, "events reset");
        rd(8'h09, 8'h00, "unmapped");
        wr(CPU_STATUS_ADDR, 8'hff);
        rd(CPU_STATUS_ADDR, 8'h3f, "status ones");
        wr(CPU_STATUS_ADDR, 8'h00);
        rd(CPU_STATUS_ADDR, 8'h2c, "status zeros");
        chk("global disable", 8'h00, global_interrupt_disable);
        wr(TIMER0_CONTROL_ADDR, 8'hff);
        rd(TIMER0_CONTROL_ADDR, 8'hfe, "control ones");
        evt(8'h40);
        rd(CPU_STATUS_ADDR, 8'h28, "sleep");
        evt(8'h20);
        rd(CPU_STATUS_ADDR, 8'h20, "timeout");
        rd(EVENT_STATUS_ADDR, 8'h10, "timeout event");
        evt(8'h80);
        rd(CPU_STATUS_ADDR, 8'h2c, "clear watchdog");
        wr(CPU_STATUS_ADDR, 8'h03);
        rd(CPU_STATUS_ADDR, 8'h2f, "flags set");
        evt(8'h04);
        rd(CPU_STATUS_ADDR, 8'h2e, "brown-out");
        evt(8'h08);
        rd(CPU_STATUS_ADDR, 8'h2c, "power-on");
        wr(CPU_STATUS_ADDR, 8'h03);
        bod <= 1'b0;
        evt(8'h04);
        rd(CPU_STATUS_ADDR, 8'h2f, "brown-out off");
        bod <= 1'b1;
        wr(EVENT_MASK_ADDR, 8'h01);
        wr(TIMER0_CONTROL_ADDR, 8'h80);
        ipin <= 1'b1;
        cyc(4);
        chk("irq rise", 8'h01, irq);
        rd(EVENT_STATUS_ADDR, 8'h01, "rise event");
        ipin <= 1'b0;
        cyc(4);
        chk("irq idle", 8'h00, irq);
        rd(EVENT_STATUS_ADDR, 8'h00, "fall ignored");
        wr(TIMER0_CONTROL_ADDR, 8'h00);
        ipin <= 1'b1;
        cyc(4);
        rd(EVENT_STATUS_ADDR, 8'h00, "rise ignored");
        ipin <= 1'b0;
        cyc(4);
        chk("irq fall", 8'h01, irq);
        wr(CPU_STATUS_ADDR, 8'h13);
        cyc(2);
        chk("irq disabled", 8'h00, irq);
        wr(CPU_STATUS_ADDR, 8'h03);
        wr(EVENT_MASK_ADDR, 8'h00);
        cyc(2);
        chk("irq masked", 8'h00, irq);
        rd(EVENT_STATUS_ADDR, 8'h01, "masked kept");
        wr(TIMER0_CONTROL_ADDR, 8'h40);
        tpin <= 1'b1;
        cyc(4);
        rd(EVENT_STATUS_ADDR, 8'h06, "pin rise");
        tpin <= 1'b0;
        cyc(4);
        rd(EVENT_STATUS_ADDR, 8'h00, "pin fall");
        wr(TIMER0_CONTROL_ADDR, 8'h00);
        tpin <= 1'b1;
        cyc(4);
        tpin <= 1'b0;
        cyc(4);
        rd(EVENT_STATUS_ADDR, 8'h06, "pin fall sel");
        wr(TIMER0_CONTROL_ADDR, 8'h60);
        tpin <= 1'b1;
        cyc(4);
        tpin <= 1'b0;
        cyc(4);
        rd(EVENT_STATUS_ADDR, 8'h02, "pin internal");
        chk("int pin flags", 8'h02, 8'(ext_seen));
        chk("timer pin flags", 8'h03, 8'(pin_seen));
        for (int i = 0; i < 10; i++) begin
            code = (i == 9) ? 4'hf : i[3:0];
            n = code[3] ? 256 : (1 << code);
            wr(TIMER0_CONTROL_ADDR, {3'h1, code, 1'h0});
            base = inc_seen;
            repeat (n - 1) tick();
            cyc(3);
            chk("early", 8'h00, 8'(inc_seen - base));
            tick();
            cyc(3);
            chk("ratio", 8'h01, 8'(inc_seen - base));
        end
        evt(8'h10);
        repeat (15) evt(8'h02);
        chk("sp top", 8'h0f, sp);
        chk("flag top", 8'h00, stk_av);
        evt(8'h02);
        chk("sp wrap", 8'h00, sp);
        evt(8'h01);
        evt(8'h02);
        chk("flag locked", 8'h00, stk_av);
        rd(EVENT_STATUS_ADDR, 8'h0c, "wrap event");
        wr(CPU_STATUS_ADDR, 8'h23);
        rd(CPU_STATUS_ADDR, 8'h0f, "lock kept");
        evt(8'h10);
        chk("flag reset", 8'h01, stk_av);
        chk("sp reset", 8'h00, sp);
        final_report();
    end
endmodule // cstc_regs_bench
